// ---- logic/ctd_control.v ----
// Conference and tone/energy-detect control registers with their timers
`include "ctd_defines.vh"
module ctd_control #(
  parameter FRAME_CYCLES = `CTD_FRAME_CYCLES,
  parameter FRAMES_PER_STEP = `CTD_FRAMES_PER_STEP
) (
  input wire ref_clk,
  input wire rst_n,
  input wire [8:0] regAddr,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regWriteData,
  output reg [7:0] regReadData,
  input wire partyAdd,
  input wire [2:0] partyConfId,
  input wire insertionToneEnable,
  input wire [3:0] confSlotIn,
  input wire confSlotValid,
  input wire [4:0] toneIndexIn,
  input wire toneValid,
  input wire [2:0] genIndexIn,
  input wire [7:0] connMemAddr,
  input wire [7:0] connMemData,
  input wire connMemWrite,
  input wire [6:0] sampleMag,
  input wire [7:0] sampleChannel,
  input wire sampleValid,
  input wire [6:0] detALow,
  input wire [6:0] detAHigh,
  input wire [6:0] detBLow,
  input wire [6:0] detBHigh,
  output reg conferenceEnable,
  output reg confOutputEnable,
  output reg insertionToneActive,
  output reg [2:0] insertionToneConf,
  output reg toneGenerationEnable,
  output reg toneOutputEnable,
  output reg genRingMode,
  output reg ringer1Active,
  output reg ringer1HighSel,
  output reg ringer2Active,
  output reg ringer2HighSel,
  output reg [6:0] peakA,
  output reg [6:0] peakB,
  output reg energyFlagA,
  output reg energyFlagB,
  output reg energyIrq
);
  // ----------------------------------------
  // Constants cut to the widths they meet
  // ----------------------------------------
  // Generators 1 and 2 sit at indices 0 and 1; the other five never ring
  localparam [2:0] GEN_RING1 = 3'h0;
  localparam [2:0] GEN_RING2 = 3'h1;
  localparam [31:0] FRAME_LAST = FRAME_CYCLES - 1;
  localparam [31:0] STEP_FRAMES = FRAMES_PER_STEP;
  localparam [31:0] SLOT_COUNT = `CTD_CONF_SLOTS;
  localparam [31:0] TONE_COUNT = `CTD_TONE_COUNT;

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  reg [7:0] confCtrl;
  reg [7:0] toneCtrl;
  reg [7:0] chanA;
  reg [7:0] chanB;
  reg [10:0] frameCount;
  reg frameTick;
  reg [12:0] toneFrames;
  reg [2:0] toneConf;
  reg toneBusy;
  reg [7:0] next_readData;
  wire [6:0] peakAw;
  wire [6:0] peakBw;
  wire flagAw;
  wire flagBw;
  wire pulseAw;
  wire pulseBw;
  wire r1a;
  wire r1h;
  wire r2a;
  wire r2h;
  wire confOn;
  wire toneOn;
  wire slotInRange;
  wire toneInRange;

  // Duration in frames for a 3-bit code
  function [12:0] durFrames;
    input [2:0] code;
    reg [31:0] frames;
    begin
      frames = ({29'h0, code} + 32'h00000001) * STEP_FRAMES;
      // Code 7 at the default step is 8000 frames, inside 13 bits
      durFrames = frames[12:0];
    end
  endfunction

  // Valid conference identifier check
  function validConf;
    input [2:0] id;
    begin
      validConf = (id >= `CTD_CONF_ID_MIN) && (id <= `CTD_CONF_ID_MAX);
    end
  endfunction

  assign confOn = confCtrl[`CTD_CONF_ENABLE_BIT];
  assign toneOn = toneCtrl[`CTD_TONE_EN_BIT];
  // Slot 15 lies past the last of the 15 conference locations
  assign slotInRange = ({1'b0, confSlotIn} < SLOT_COUNT[4:0]);
  // Always true at 5 bits, but keeps the tone limit tied to the index
  assign toneInRange = ({1'b0, toneIndexIn} < TONE_COUNT[5:0]);

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      confCtrl <= `CTD_RESET_VALUE;
      toneCtrl <= `CTD_RESET_VALUE;
    end else if (regWrite) begin
      if (regAddr == `CTD_ADDR_CONF_CTRL) begin
        confCtrl <= regWriteData & `CTD_CONF_MASK;
      end
      if (regAddr == `CTD_ADDR_TONE_DET_CTRL) begin
        toneCtrl <= regWriteData & `CTD_TONE_MASK;
      end
    end
  end

  // Unused bits read as zero; unmapped addresses read zero
  always @* begin
    next_readData = 8'h00;
    if (regRead && regAddr == `CTD_ADDR_CONF_CTRL) begin
      next_readData = confCtrl;
    end else if (regRead && regAddr == `CTD_ADDR_TONE_DET_CTRL) begin
      next_readData = toneCtrl;
    end
  end

  // Registered so the read value stands a full cycle
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      regReadData <= 8'h00;
    end else begin
      regReadData <= next_readData;
    end
  end

  // ----------------------------------------
  // Detector channel selection
  // ----------------------------------------
  // Only the two detector words of connection memory are kept here
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      chanA <= 8'h00;
      chanB <= 8'h00;
    end else if (connMemWrite) begin
      if (connMemAddr == `CTD_DET_A_CM_LOC) begin
        chanA <= connMemData;
      end
      if (connMemAddr == `CTD_DET_B_CM_LOC) begin
        chanB <= connMemData;
      end
    end
  end

  // ----------------------------------------
  // 8 kHz frame tick
  // ----------------------------------------
  // One shared tick keeps both ringers and the tone timer on the same frames
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      frameCount <= 11'h000;
      frameTick <= 1'b0;
    end else if (frameCount == FRAME_LAST[10:0]) begin
      frameCount <= 11'h000;
      frameTick <= 1'b1;
    end else begin
      frameCount <= frameCount + 11'h001;
      frameTick <= 1'b0;
    end
  end

  // ----------------------------------------
  // Insertion tone timer
  // ----------------------------------------
  // A new party restarts the timer; only one tone runs at a time
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      toneFrames <= 13'h0000;
      toneConf <= 3'h0;
      toneBusy <= 1'b0;
    end else if (!confOn) begin
      toneFrames <= 13'h0000;
      toneConf <= 3'h0;
      toneBusy <= 1'b0;
    end else if (partyAdd && insertionToneEnable && validConf(partyConfId)) begin
      toneFrames <= durFrames(confCtrl[`CTD_DUR_MSB:`CTD_DUR_LSB]);
      toneConf <= partyConfId;
      toneBusy <= 1'b1;
    end else if (toneBusy && frameTick) begin
      if (toneFrames == 13'h0001) begin
        toneBusy <= 1'b0;
        toneFrames <= 13'h0000;
      end else begin
        toneFrames <= toneFrames - 13'h0001;
      end
    end
  end

  // ----------------------------------------
  // Ringers and detectors
  // ----------------------------------------
  ctd_ringer ringer1 (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .frameTick(frameTick),
    .toneEnable(toneOn),
    .ringerEnable(toneCtrl[`CTD_RINGER1_BIT]),
    .warbleSlow(toneCtrl[`CTD_WARBLE1_BIT]),
    .ringing(r1a),
    .highFreqSel(r1h)
  );

  ctd_ringer ringer2 (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .frameTick(frameTick),
    .toneEnable(toneOn),
    .ringerEnable(toneCtrl[`CTD_RINGER2_BIT]),
    .warbleSlow(toneCtrl[`CTD_WARBLE2_BIT]),
    .ringing(r2a),
    .highFreqSel(r2h)
  );

  ctd_detector detA (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .enable(toneCtrl[`CTD_DET_A_BIT]),
    .sampleValid(sampleValid && sampleChannel == chanA),
    .sampleMag(sampleMag),
    .lowThreshold(detALow),
    .highThreshold(detAHigh),
    .peak(peakAw),
    .detectFlag(flagAw),
    .detectPulse(pulseAw)
  );

  ctd_detector detB (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .enable(toneCtrl[`CTD_DET_B_BIT]),
    .sampleValid(sampleValid && sampleChannel == chanB),
    .sampleMag(sampleMag),
    .lowThreshold(detBLow),
    .highThreshold(detBHigh),
    .peak(peakBw),
    .detectFlag(flagBw),
    .detectPulse(pulseBw)
  );

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      conferenceEnable <= 1'b0;
      confOutputEnable <= 1'b0;
      insertionToneActive <= 1'b0;
      insertionToneConf <= 3'h0;
      toneGenerationEnable <= 1'b0;
      toneOutputEnable <= 1'b0;
      genRingMode <= 1'b0;
      ringer1Active <= 1'b0;
      ringer1HighSel <= 1'b0;
      ringer2Active <= 1'b0;
      ringer2HighSel <= 1'b0;
      peakA <= 7'h00;
      peakB <= 7'h00;
      energyFlagA <= 1'b0;
      energyFlagB <= 1'b0;
      energyIrq <= 1'b0;
    end else begin
      conferenceEnable <= confOn;
      confOutputEnable <= confOn && confSlotValid && slotInRange;
      insertionToneActive <= toneBusy && confOn;
      insertionToneConf <= toneBusy ? toneConf : 3'h0;
      toneGenerationEnable <= toneOn;
      toneOutputEnable <= toneOn && toneValid && toneInRange;
      // Generator index: only first two may ring
      genRingMode <= toneOn && ((genIndexIn == GEN_RING1 && r1a) ||
        (genIndexIn == GEN_RING2 && r2a));
      ringer1Active <= r1a && toneOn;
      ringer1HighSel <= r1h;
      ringer2Active <= r2a && toneOn;
      ringer2HighSel <= r2h;
      peakA <= peakAw;
      peakB <= peakBw;
      energyFlagA <= flagAw;
      energyFlagB <= flagBw;
      energyIrq <= pulseAw | pulseBw;
    end
  end
endmodule // ctd_control

// ---- logic/ctd_defines.vh ----
// Constants for the conference and tone/detect control block
// Contract
// - Conference control bit 0 low holds conference block reset; high lets it run.
// - Conference in reset gives no output in any of 15 conference slots.
// - Duration field bits 3..1 selects (code+1) times 0.125 s.
// - Party added with insertion tone enabled gets tone for programmed duration.
// - Bit 6 resets tone generation when low; software sets it before ringers/FSK.
// - Tone generation in reset gives no output for all 32 tones.
// - Bit 5 high makes generator 2 a square ringer, else DTMF.
// - Bit 4 high warbles ringer 2 at 5 Hz, low at 10 Hz.
// - Bits 3 and 2 control ringer 1 like bits 5 and 4.
// - Only generators 1 and 2 of seven may ring.
// - Bit 1 enables detector B, bit 0 detector A.
// - Detectors watch channels from connection memory 71h (A) and 72h (B).
// - Signal above a detector threshold sets its flag and raises interrupt.
// - Clearing a detector enable zeroes its peak value and flag.
// - Thresholds are 7-bit magnitudes: chord bits 6..4, step bits 3..0.
`ifndef CTD_DEFINES_VH
`define CTD_DEFINES_VH
// ----------------------------------------
// Register map
// ----------------------------------------
`define CTD_ADDR_CONF_CTRL 9'h009
`define CTD_ADDR_TONE_DET_CTRL 9'h010
`define CTD_RESET_VALUE 8'h00
// ----------------------------------------
// Conference control fields
// ----------------------------------------
`define CTD_CONF_ENABLE_BIT 0
`define CTD_DUR_LSB 1
`define CTD_DUR_MSB 3
`define CTD_CONF_MASK 8'h0F
// ----------------------------------------
// Tone and detect control fields
// ----------------------------------------
`define CTD_DET_A_BIT 0
`define CTD_DET_B_BIT 1
`define CTD_WARBLE1_BIT 2
`define CTD_RINGER1_BIT 3
`define CTD_WARBLE2_BIT 4
`define CTD_RINGER2_BIT 5
`define CTD_TONE_EN_BIT 6
`define CTD_TONE_MASK 8'h7F
// ----------------------------------------
// Timing, in 8 kHz frames
// ----------------------------------------
`define CTD_CLK_HZ 10000000
`define CTD_FRAME_HZ 8000
`define CTD_FRAME_CYCLES (`CTD_CLK_HZ / `CTD_FRAME_HZ)
`define CTD_STEP_MS 125
`define CTD_FRAMES_PER_STEP ((`CTD_FRAME_HZ * `CTD_STEP_MS) / 1000)
`define CTD_WARBLE_FAST_HZ 10
`define CTD_WARBLE_SLOW_HZ 5
`define CTD_HALF_FAST ((`CTD_FRAME_HZ / `CTD_WARBLE_FAST_HZ) / 2)
`define CTD_HALF_SLOW ((`CTD_FRAME_HZ / `CTD_WARBLE_SLOW_HZ) / 2)
// ----------------------------------------
// Sizes
// ----------------------------------------
`define CTD_CONF_SLOTS 15
`define CTD_TONE_COUNT 32
`define CTD_GEN_COUNT 7
`define CTD_DET_A_CM_LOC 8'h71
`define CTD_DET_B_CM_LOC 8'h72
`define CTD_CONF_ID_MIN 3'h1
`define CTD_CONF_ID_MAX 3'h5
`endif

// ---- logic/ctd_ringer.v ----
// Warbling square-wave ringer control for one programmable generator
`include "ctd_defines.vh"
module ctd_ringer (
  input wire ref_clk,
  input wire rst_n,
  input wire frameTick,
  input wire toneEnable,
  input wire ringerEnable,
  input wire warbleSlow,
  output reg ringing,
  output reg highFreqSel
);
  reg [9:0] halfCount;
  wire [9:0] halfLimit;
  wire active;
  localparam [31:0] SLOW_LAST = `CTD_HALF_SLOW - 1;
  localparam [31:0] FAST_LAST = `CTD_HALF_FAST - 1;

  assign active = toneEnable & ringerEnable;
  // Slow bit picks 5 Hz, else 10 Hz
  assign halfLimit = warbleSlow ? SLOW_LAST[9:0] : FAST_LAST[9:0];

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      halfCount <= 10'h000;
      highFreqSel <= 1'b0;
      ringing <= 1'b0;
    end else begin
      ringing <= active;
      if (!active) begin
        halfCount <= 10'h000;
        highFreqSel <= 1'b0;
      end else if (frameTick) begin
        if (halfCount >= halfLimit) begin
          halfCount <= 10'h000;
          highFreqSel <= ~highFreqSel;
        end else begin
          halfCount <= halfCount + 10'h001;
        end
      end
    end
  end
endmodule // ctd_ringer

// ---- logic/ctd_detector.v ----
// Energy detector control: peak capture, threshold compare, flag
`include "ctd_defines.vh"
module ctd_detector (
  input wire ref_clk,
  input wire rst_n,
  input wire enable,
  input wire sampleValid,
  input wire [6:0] sampleMag,
  input wire [6:0] lowThreshold,
  input wire [6:0] highThreshold,
  output reg [6:0] peak,
  output reg detectFlag,
  output reg detectPulse
);
  wire over;

  // Chord in 6..4, step in 3..0: plain unsigned compare orders them
  assign over = (sampleMag > lowThreshold) | (sampleMag > highThreshold);

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      peak <= 7'h00;
      detectFlag <= 1'b0;
      detectPulse <= 1'b0;
    end else if (!enable) begin
      peak <= 7'h00;
      detectFlag <= 1'b0;
      detectPulse <= 1'b0;
    end else begin
      detectPulse <= sampleValid & over & ~detectFlag;
      if (sampleValid & (sampleMag > peak)) begin
        peak <= sampleMag;
      end
      if (sampleValid & over) begin
        detectFlag <= 1'b1;
      end
    end
  end
endmodule // ctd_detector

// ---- test/ctd_control_props.sv ----
// Port-level assertions for the conference and tone/detect control block
module ctd_control_props (
  input wire ref_clk,
  input wire rst_n,
  input wire [8:0] regAddr,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regWriteData,
  input wire [7:0] regReadData,
  input wire partyAdd,
  input wire [2:0] partyConfId,
  input wire insertionToneEnable,
  input wire [3:0] confSlotIn,
  input wire confSlotValid,
  input wire toneValid,
  input wire conferenceEnable,
  input wire confOutputEnable,
  input wire insertionToneActive,
  input wire [2:0] insertionToneConf,
  input wire toneGenerationEnable,
  input wire toneOutputEnable,
  input wire ringer1Active,
  input wire ringer2Active,
  input wire [6:0] peakA,
  input wire energyFlagA,
  input wire energyFlagB,
  input wire energyIrq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  a_conf_en_follow: assert property (
    regWrite && regAddr == 9'h009 |=> ##1 conferenceEnable == $past(regWriteData[0], 2))
    else $error("conference enable does not follow its bit");
  a_conf_out_gate: assert property (
    confOutputEnable |-> $past(confSlotValid) && $past(confSlotIn) != 4'hF
      && (conferenceEnable || $past(conferenceEnable)))
    else $error("conference output without cause");
  a_tone_out_gate: assert property (
    toneOutputEnable |-> $past(toneValid) && (toneGenerationEnable || $past(toneGenerationEnable)))
    else $error("tone output without cause");
  a_ringer_held_off: assert property (
    !toneGenerationEnable [*3] |-> !ringer1Active && !ringer2Active)
    else $error("ringer active while tone generation held");
  a_party_taken: assert property (
    partyAdd && partyConfId != 3'h0 && partyConfId < 3'h6 && insertionToneEnable
      && conferenceEnable |-> ##2 insertionToneActive && insertionToneConf == $past(partyConfId, 2))
    else $error("insertion tone not started");
  a_party_refused: assert property (
    partyAdd && (partyConfId == 3'h0 || partyConfId > 3'h5) && !insertionToneActive
      && !$past(partyAdd) |-> ##2 !insertionToneActive)
    else $error("tone started for bad conference id");
  a_det_cleared: assert property (
    regWrite && regAddr == 9'h010 && !regWriteData[0] |-> ##3 peakA == 7'h00 && !energyFlagA)
    else $error("detector A not cleared");
  a_irq_on_flag: assert property (
    $rose(energyFlagA) || $rose(energyFlagB) |-> energyIrq)
    else $error("detection without interrupt");
  a_cc_upper_zero: assert property (
    regRead && regAddr == 9'h009 |=> regReadData[7:4] == 4'h0)
    else $error("unused conference bits read back set");
endmodule // ctd_control_props

bind ctd_control ctd_control_props u_ctd_control_props (
  .ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrite(regWrite),
  .regRead(regRead), .regWriteData(regWriteData), .regReadData(regReadData),
  .partyAdd(partyAdd), .partyConfId(partyConfId),
  .insertionToneEnable(insertionToneEnable), .confSlotIn(confSlotIn),
  .confSlotValid(confSlotValid), .toneValid(toneValid),
  .conferenceEnable(conferenceEnable), .confOutputEnable(confOutputEnable),
  .insertionToneActive(insertionToneActive), .insertionToneConf(insertionToneConf),
  .toneGenerationEnable(toneGenerationEnable), .toneOutputEnable(toneOutputEnable),
  .ringer1Active(ringer1Active), .ringer2Active(ringer2Active), .peakA(peakA),
  .energyFlagA(energyFlagA), .energyFlagB(energyFlagB), .energyIrq(energyIrq)
);

// ---- test/ctd_control_tb_top.sv ----
// Self-checking bench for the conference and tone/detect control block
module ctd_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0, rst_n = 1'b0, regWrite = 1'b0, regRead = 1'b0;
  logic partyAdd = 1'b0, insertionToneEnable = 1'b0, confSlotValid = 1'b0, toneValid = 1'b0;
  logic connMemWrite = 1'b0, sampleValid = 1'b0;
  logic [8:0] regAddr = 9'h000;
  logic [7:0] regWriteData = 8'h00, connMemAddr = 8'h00, connMemData = 8'h00;
  logic [7:0] sampleChannel = 8'h00;
  logic [2:0] partyConfId = 3'h0, genIndexIn = 3'h0;
  logic [3:0] confSlotIn = 4'h0;
  logic [4:0] toneIndexIn = 5'h00;
  logic [6:0] sampleMag = 7'h00, detALow = 7'h20, detAHigh = 7'h7F, detBLow = 7'h7F;
  logic [6:0] detBHigh = 7'h7F;
  wire [7:0] regReadData;
  wire [6:0] peakA, peakB;
  wire [2:0] insertionToneConf;
  wire conferenceEnable, confOutputEnable, insertionToneActive, toneGenerationEnable;
  wire toneOutputEnable, genRingMode, ringer1Active, ringer1HighSel, ringer2Active;
  wire ringer2HighSel, energyFlagA, energyFlagB, energyIrq;
  wire [3:0] toneState = {toneGenerationEnable, ringer1Active, ringer2Active, toneOutputEnable};
  int n_fail = 0;
  int checks_done = 0;

  // Short frames and steps keep the timer runs brief
  ctd_control #(.FRAME_CYCLES(4), .FRAMES_PER_STEP(3)) u_ctd_control (
    .ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrite(regWrite),
    .regRead(regRead), .regWriteData(regWriteData), .regReadData(regReadData),
    .partyAdd(partyAdd), .partyConfId(partyConfId),
    .insertionToneEnable(insertionToneEnable), .confSlotIn(confSlotIn),
    .confSlotValid(confSlotValid), .toneIndexIn(toneIndexIn), .toneValid(toneValid),
    .genIndexIn(genIndexIn), .connMemAddr(connMemAddr), .connMemData(connMemData),
    .connMemWrite(connMemWrite), .sampleMag(sampleMag), .sampleChannel(sampleChannel),
    .sampleValid(sampleValid), .detALow(detALow), .detAHigh(detAHigh),
    .detBLow(detBLow), .detBHigh(detBHigh),
    .conferenceEnable(conferenceEnable), .confOutputEnable(confOutputEnable),
    .insertionToneActive(insertionToneActive), .insertionToneConf(insertionToneConf),
    .toneGenerationEnable(toneGenerationEnable), .toneOutputEnable(toneOutputEnable),
    .genRingMode(genRingMode), .ringer1Active(ringer1Active),
    .ringer1HighSel(ringer1HighSel), .ringer2Active(ringer2Active),
    .ringer2HighSel(ringer2HighSel), .peakA(peakA), .peakB(peakB),
    .energyFlagA(energyFlagA), .energyFlagB(energyFlagB), .energyIrq(energyIrq)
  );

  initial forever #50 ref_clk = ~ref_clk;

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Frame-based timers land within two frames of the ideal
  task automatic chk_span(input string what, input int exp, input int got);
    checks_done++;
    if (got < exp - 8 || got > exp + 8) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWriteData <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [8:0] a, input logic [7:0] exp, input string what);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    @(negedge ref_clk);
    chk(what, exp, regReadData);
  endtask

  task automatic party(input logic [2:0] id);
    @(posedge ref_clk);
    partyAdd <= 1'b1;
    partyConfId <= id;
    @(posedge ref_clk);
    partyAdd <= 1'b0;
  endtask

  task automatic sample(input logic [7:0] ch, input logic [6:0] mag);
    @(posedge ref_clk);
    sampleValid <= 1'b1;
    sampleChannel <= ch;
    sampleMag <= mag;
    @(posedge ref_clk);
    sampleValid <= 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask

  task automatic t_regs;
    rd(9'h009, 8'h00, "cc reset");
    rd(9'h010, 8'h00, "tone_and_detect_control reset");
    wr(9'h009, 8'hFF);
    rd(9'h009, 8'h0F, "cc mask");
    wr(9'h010, 8'hFF);
    rd(9'h010, 8'h7F, "tone_and_detect_control mask");
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(9'h009, 8'h00, "cc mid reset");
    rd(9'h010, 8'h00, "tone_and_detect_control mid reset");
    wr(9'h011, 8'h5A);
    rd(9'h011, 8'h00, "unmapped");
    wr(9'h009, 8'h00);
    wr(9'h010, 8'h00);
    $display("test regs done");
  endtask

  task automatic t_conf;
    @(posedge ref_clk);
    confSlotValid <= 1'b1;
    confSlotIn <= 4'hE;
    settle(3);
    chk("conf out held", 8'h00, 8'(confOutputEnable));
    wr(9'h009, 8'h01);
    settle(2);
    chk("conf enable", 8'h01, 8'(conferenceEnable));
    chk("conf out slot 14", 8'h01, 8'(confOutputEnable));
    @(posedge ref_clk);
    confSlotIn <= 4'hF;
    settle(2);
    chk("conf out slot 15", 8'h00, 8'(confOutputEnable));
    $display("test conf done");
  endtask

  task automatic t_tone;
    int n;
    @(posedge ref_clk);
    insertionToneEnable <= 1'b1;
    for (int c = 0; c < 8; c += 7) begin
      wr(9'h009, 8'(c * 2 + 1));
      party(3'h3);
      settle(1);
      chk("tone conf", 8'h03, 8'(insertionToneConf));
      n = 1;
      repeat (140) begin
        @(negedge ref_clk);
        if (insertionToneActive === 1'b1) n++;
      end
      chk_span("tone length", 12 * (c + 1), n);
    end
    party(3'h6);
    settle(4);
    chk("bad id", 8'h00, 8'(insertionToneActive));
    $display("test tone done");
  endtask

  task automatic t_ring;
    logic p1, p2;
    int t1, t2, d1, d2;
    @(posedge ref_clk);
    toneValid <= 1'b1;
    wr(9'h010, 8'h2C);
    settle(4);
    chk("ringers held", 8'h00, 8'(toneState));
    wr(9'h010, 8'h6C);
    settle(4);
    chk("ringers on", 8'h0F, 8'(toneState));
    for (int g = 0; g < 7; g++) begin
      @(posedge ref_clk);
      genIndexIn <= 3'(g);
      settle(2);
      chk("ring mode", 8'(g < 2), 8'(genRingMode));
    end
    p1 = ringer1HighSel;
    p2 = ringer2HighSel;
    t1 = 0;
    t2 = 0;
    d1 = 0;
    d2 = 0;
    for (int i = 0; i < 7000; i++) begin
      @(negedge ref_clk);
      if (ringer1HighSel !== p1) begin
        d1 = i - t1;
        t1 = i;
      end
      if (ringer2HighSel !== p2) begin
        d2 = i - t2;
        t2 = i;
      end
      p1 = ringer1HighSel;
      p2 = ringer2HighSel;
    end
    chk_span("warble slow", 3200, d1);
    chk_span("warble fast", 1600, d2);
    wr(9'h010, 8'h04);
    settle(4);
    chk("ringers off", 8'h00, 8'(toneState));
    $display("test ring done");
  endtask

  task automatic t_det;
    @(posedge ref_clk);
    connMemWrite <= 1'b1;
    connMemAddr <= 8'h71;
    connMemData <= 8'h05;
    @(posedge ref_clk);
    connMemWrite <= 1'b0;
    sample(8'h05, 7'h45);
    chk("det off", 8'h00, 8'(energyFlagA));
    wr(9'h010, 8'h01);
    settle(2);
    sample(8'h09, 7'h45);
    chk("other chan", 8'h00, 8'(energyFlagA));
    sample(8'h05, 7'h1F);
    chk("below chord", 8'h00, 8'(energyFlagA));
    sample(8'h05, 7'h45);
    chk("irq", 8'h01, 8'(energyIrq));
    chk("flag", 8'h01, 8'(energyFlagA));
    chk("peak", 8'h45, 8'(peakA));
    @(posedge ref_clk);
    connMemWrite <= 1'b1;
    connMemAddr <= 8'h72;
    connMemData <= 8'h07;
    detBHigh <= 7'h30;
    @(posedge ref_clk);
    connMemWrite <= 1'b0;
    wr(9'h010, 8'h03);
    settle(2);
    sample(8'h05, 7'h45);
    chk("det b other chan", 8'h00, 8'(energyFlagB));
    sample(8'h07, 7'h45);
    chk("irq b", 8'h01, 8'(energyIrq));
    chk("flag b", 8'h01, 8'(energyFlagB));
    chk("peak b", 8'h45, 8'(peakB));
    wr(9'h010, 8'h00);
    settle(3);
    chk("cleared", 8'h00, 8'({energyFlagA, peakA}));
    chk("cleared b", 8'h00, 8'({energyFlagB, peakB}));
    $display("test det done");
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_regs;
    t_conf;
    t_tone;
    t_ring;
    t_det;
    complete_run;
  end

  // About 8000 cycles are expected; five times that means a hang
  initial begin
    repeat (40000) @(posedge ref_clk);
    n_fail++;
    complete_run;
  end
endmodule // ctd_control_tb_top
